// ### verilog/rtu_slave_pkg.sv
// Package: constants, state type and checksum for the serial register slave
package rtu_slave_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20_000_000; // Core clock rate
  localparam int BAUD = 9600; // Fixed line rate
  localparam int BIT_CYCLES = CLK_HZ / BAUD; // One bit time
  localparam int CHAR_BITS = 10; // Start, eight data, stop
  localparam int GAP_TENTHS = 35; // Idle gap, tenths of a character
  localparam int GAP_CYCLES_DEF = (CLK_HZ / 10 * CHAR_BITS * GAP_TENTHS + BAUD - 1) / BAUD;
  localparam logic [3:0] LAST_BIT = 4'(CHAR_BITS - 1);
  localparam int FIFO_DEPTH = 4; // Response buffer depth

  // ==========================================================
  // Function and exception codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] FC_EXC_BIT = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] RD_BYTE_COUNT = 8'h02;
  localparam logic [15:0] RD_WORD_COUNT = 16'h0001;

  // ==========================================================
  // Register map
  localparam logic [15:0] REG_RUN_CMD = 16'h0001;
  localparam logic [15:0] REG_OP_STATE = 16'h0002;
  localparam logic [15:0] REG_MEAN_CUR = 16'h0003;
  localparam logic [15:0] REG_FAULT = 16'h0004;
  localparam logic [15:0] REG_PARAM_FIRST = 16'h0100;
  localparam logic [15:0] REG_PARAM_LAST = 16'h0112;
  localparam int PARAM_COUNT = 19;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [15:0] PARAM_LIMIT = 16'h270F; // Largest accepted value
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam logic [15:0] CMD_UNUSED_MASK = 16'hFFF8;

  // ==========================================================
  // Checksum
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // Gray coded along idle, execute, send, checksum, drain
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EXEC = 3'h1,
    ST_SEND = 3'h3,
    ST_CRCL = 3'h2,
    ST_CRCH = 3'h6,
    ST_DRAIN = 3'h7
  } slave_state_t;

  // One byte through the reflected checksum
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte
endpackage : rtu_slave_pkg

// ### verilog/char_link_if.sv
// Interface: byte stream with valid and ready
`timescale 1ns/1ps
`default_nettype none
interface char_link_if #(parameter int W = 8);
  logic [W-1:0] data; // Byte offered
  logic valid; // Source has a byte
  logic ready; // Sink takes it
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : char_link_if
`default_nettype wire

// ### verilog/char_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  char_link_if.snk wr,
  char_link_if.src rd,
  output logic o_empty
);
  // ==========================================================
  // Storage and pointers; depth must be a power of two
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1]; // Flip-flop storage
  logic [AW:0] wp_reg; // Write pointer with wrap bit
  logic [AW:0] rp_reg; // Read pointer with wrap bit
  wire logic full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire logic empty = wp_reg == rp_reg;
  wire logic do_wr = wr.valid && !full;
  wire logic do_rd = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem_reg[rp_reg[AW-1:0]];
  assign o_empty = empty;

  // Data words carry no reset; only pointers need one
  always_ff @(posedge i_clk) begin
    if (i_ce && do_wr) begin
      mem_reg[wp_reg[AW-1:0]] <= wr.data;
    end
  end

  // Pointer update
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (i_ce) begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule : char_fifo
`default_nettype wire

// ### verilog/serial_char_port.sv
// Asynchronous character receiver and transmitter, 8N1
`timescale 1ns/1ps
`default_nettype none
module serial_char_port #(
  parameter int BIT_CYC = rtu_slave_pkg::BIT_CYCLES // Cycles per line bit
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_rxd,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_txd,
  output logic o_tx_busy,
  char_link_if.snk tx_in
);
  import rtu_slave_pkg::*;
  // Bit counts follow the parameter so a bench can shorten the bit
  localparam logic [11:0] BIT_CNT_MAX = 12'(BIT_CYC - 1); // Last count of a bit
  localparam logic [11:0] HALF_BIT_CNT = 12'(BIT_CYC / 2 - 1); // Count to mid start bit

  // ==========================================================
  // Receiver: samples mid-bit, start is bit 0, stop is bit 9
  logic rx_on_reg; // Character in progress
  logic [3:0] rx_bit_reg; // Bit index
  logic [11:0] rx_cnt_reg; // Cycles to next sample
  logic [7:0] rx_sh_reg; // Data, LSB first
  logic rx_valid_reg; // Strobe for a good character

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_on_reg <= 1'b0;
      rx_bit_reg <= 4'h0;
      rx_cnt_reg <= 12'h000;
      rx_sh_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else if (i_ce) begin
      rx_valid_reg <= 1'b0;
      if (!rx_on_reg) begin
        if (!i_rxd) begin
          rx_on_reg <= 1'b1;
          rx_bit_reg <= 4'h0;
          rx_cnt_reg <= HALF_BIT_CNT;
        end
      end else if (rx_cnt_reg != 12'h000) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end else begin
        rx_cnt_reg <= BIT_CNT_MAX;
        rx_bit_reg <= rx_bit_reg + 1'b1;
        if (rx_bit_reg == 4'h0) begin
          rx_on_reg <= !i_rxd; // Glitch, not a start bit
        end else if (rx_bit_reg == LAST_BIT) begin
          rx_on_reg <= 1'b0;
          rx_valid_reg <= i_rxd; // Bad stop bit drops the byte
        end else begin
          rx_sh_reg <= {i_rxd, rx_sh_reg[7:1]};
        end
      end
    end
  end

  assign o_rx_data = rx_sh_reg;
  assign o_rx_valid = rx_valid_reg;

  // ==========================================================
  // Transmitter: line idles high through the all-ones shifter
  logic tx_on_reg; // Character in progress
  logic [3:0] tx_bit_reg; // Bit index
  logic [11:0] tx_cnt_reg; // Cycles left in this bit
  logic [9:0] tx_sh_reg; // Stop, data, start

  assign tx_in.ready = !tx_on_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_on_reg <= 1'b0;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 12'h000;
      tx_sh_reg <= 10'h3FF;
    end else if (i_ce) begin
      if (!tx_on_reg) begin
        if (tx_in.valid) begin
          tx_on_reg <= 1'b1;
          tx_bit_reg <= 4'h0;
          tx_cnt_reg <= BIT_CNT_MAX;
          tx_sh_reg <= {1'b1, tx_in.data, 1'b0};
        end
      end else if (tx_cnt_reg != 12'h000) begin
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end else begin
        tx_cnt_reg <= BIT_CNT_MAX;
        tx_bit_reg <= tx_bit_reg + 1'b1;
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        if (tx_bit_reg == LAST_BIT) begin
          tx_on_reg <= 1'b0;
        end
      end
    end
  end

  assign o_txd = tx_sh_reg[0];
  assign o_tx_busy = tx_on_reg;
endmodule : serial_char_port
`default_nettype wire

// ### verilog/rtu_register_slave.sv
// Top level: serial register slave of a motor starter, read and write one word
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Behaviour
// - Line runs 9600 baud, 8N1
// - Frame: address, function, data, checksum
// - Only read and single write accepted
// - Reads move whole 16-bit words only
// - Decode command, status, current, fault, parameters
// - Unmapped register access answered by exception
// - Command bits: start, stop, fault reset
// - Good write echoed back unchanged
// - Status: starting, running, soft stop, fault
// - Read reply: address, 03, 02, word
// - Current register holds amperes times ten
// - Fault cause valid while fault bit set
// - Parameters at 0x0100 to 0x0112 by index
// - Exception 01 for unsupported function
// - Exception 02 for bad register address
// - Exception 03 for rejected written value
module rtu_register_slave #(
  parameter int GAP_CYCLES = rtu_slave_pkg::GAP_CYCLES_DEF, // Idle gap in cycles
  parameter int BIT_CYC = rtu_slave_pkg::BIT_CYCLES // Cycles per line bit
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_RXD,
  input wire logic [7:0] I_STATION_ADDR,
  input wire logic I_STARTING,
  input wire logic I_RUNNING,
  input wire logic I_SOFT_STOPPING,
  input wire logic I_FAULT,
  input wire logic [15:0] I_MEAN_CURRENT,
  input wire logic [15:0] I_FAULT_CAUSE,
  input wire logic [rtu_slave_pkg::PARAM_COUNT-1:0] I_PARAM_FIXED,
  input wire logic [rtu_slave_pkg::PARAM_COUNT-1:0] I_PARAM_RUN_LOCKED,
  output logic O_TXD,
  output logic O_TX_EN,
  output logic O_START_REQ,
  output logic O_STOP_REQ,
  output logic O_FAULT_RESET_REQ,
  output logic O_PARAM_WR,
  output logic [4:0] O_PARAM_IDX,
  output logic [15:0] O_PARAM_DATA
);
  import rtu_slave_pkg::*;

  // ==========================================================
  // Character port and response buffer
  logic [7:0] rx_data; // Received byte
  logic rx_valid; // One strobe per good byte
  logic tx_busy; // Transmitter shifting
  logic fifo_empty; // Nothing left to send
  char_link_if to_fifo(); // Response bytes in
  char_link_if from_fifo(); // Bytes to the line

  serial_char_port #(.BIT_CYC(BIT_CYC)) u_port (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_rxd(I_RXD),
    .o_rx_data(rx_data),
    .o_rx_valid(rx_valid),
    .o_txd(O_TXD),
    .o_tx_busy(tx_busy),
    .tx_in(from_fifo.snk)
  );

  // Buffer lets framing run ahead of the slow line
  char_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .wr(to_fifo.snk),
    .rd(from_fifo.src),
    .o_empty(fifo_empty)
  );

  // ==========================================================
  // Request capture
  slave_state_t state_reg; // Sequencer state
  slave_state_t state_next; // Its next value
  logic [7:0] rx_buf_reg [0:7]; // First eight request bytes
  logic [3:0] rx_cnt_reg; // Bytes in frame, saturating
  logic [15:0] rx_crc_reg; // Running checksum
  logic [16:0] gap_cnt_reg; // Idle cycles since last byte
  wire logic accept = rx_valid && state_reg == ST_IDLE;
  wire logic gap_full = gap_cnt_reg == 17'(GAP_CYCLES - 1);
  wire logic frame_end = state_reg == ST_IDLE && rx_cnt_reg != 4'h0 && gap_full;

  // Idle timer restarts on every byte
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      gap_cnt_reg <= 17'h00000;
    end else if (I_CE) begin
      if (rx_valid) begin
        gap_cnt_reg <= 17'h00000;
      end else if (!gap_full) begin
        gap_cnt_reg <= gap_cnt_reg + 1'b1;
      end
    end
  end

  // Bytes are kept only while idle; talk during a reply is dropped
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rx_cnt_reg <= 4'h0;
      rx_crc_reg <= CRC_INIT;
    end else if (I_CE) begin
      if (frame_end) begin
        rx_cnt_reg <= 4'h0;
        rx_crc_reg <= CRC_INIT;
      end else if (accept) begin
        rx_cnt_reg <= (rx_cnt_reg == 4'hF) ? rx_cnt_reg : rx_cnt_reg + 1'b1;
        rx_crc_reg <= crc16_byte(rx_crc_reg, rx_data);
      end
    end
  end

  // Byte store; extra bytes only feed the checksum and the byte count
  always_ff @(posedge I_CORE_CLK) begin
    if (I_CE && accept && !rx_cnt_reg[3]) begin
      rx_buf_reg[rx_cnt_reg[2:0]] <= rx_data;
    end
  end

  // ==========================================================
  // Request decode
  wire logic [7:0] req_fc = rx_buf_reg[1];
  wire logic is_rd = req_fc == FC_READ;
  wire logic is_wr = req_fc == FC_WRITE;
  wire logic [15:0] req_addr = {rx_buf_reg[2], rx_buf_reg[3]};
  wire logic [15:0] req_val = {rx_buf_reg[4], rx_buf_reg[5]};
  wire logic is_param = req_addr >= REG_PARAM_FIRST && req_addr <= REG_PARAM_LAST;
  wire logic [4:0] pidx = 5'(req_addr - REG_PARAM_FIRST);
  wire logic is_cmd = req_addr == REG_RUN_CMD;
  wire logic rd_addr_ok = is_param || req_addr == REG_OP_STATE || req_addr == REG_MEAN_CUR
    || req_addr == REG_FAULT;
  wire logic wr_addr_ok = is_param || is_cmd;
  wire logic motor_busy = I_STARTING || I_RUNNING || I_SOFT_STOPPING;
  // Checksum residue is zero when the two trailing bytes match, low byte first
  wire logic frame_good = rx_crc_reg == 16'h0000 && rx_buf_reg[0] == I_STATION_ADDR
    && rx_cnt_reg >= 4'h4 && (!(is_rd || is_wr) || rx_cnt_reg == 4'h8);

  // Parameter value checks: range, fixed, locked while motor moves
  wire logic param_bad = req_val > PARAM_LIMIT || I_PARAM_FIXED[pidx]
    || (I_PARAM_RUN_LOCKED[pidx] && motor_busy);
  wire logic val_bad = is_param ? param_bad : (req_val & CMD_UNUSED_MASK) != 16'h0000;

  // Exception priority: function, then address, then value
  wire logic [7:0] exc_code = !(is_rd || is_wr) ? EXC_FUNC :
    (is_rd && (!rd_addr_ok || req_val != RD_WORD_COUNT)) ? EXC_ADDR :
    (is_wr && !wr_addr_ok) ? EXC_ADDR :
    (is_wr && val_bad) ? EXC_VALUE : EXC_NONE;
  wire logic good_rd = is_rd && exc_code == EXC_NONE;
  wire logic good_wr = is_wr && exc_code == EXC_NONE;

  // ==========================================================
  // Register map contents
  logic [15:0] param_reg [0:PARAM_COUNT-1]; // Tuning parameters
  wire logic [15:0] state_word = {12'h000, I_FAULT, I_SOFT_STOPPING, I_RUNNING, I_STARTING};
  // Current and fault cause pass through as supplied
  wire logic [15:0] rd_value = is_param ? param_reg[pidx] :
    req_addr == REG_OP_STATE ? state_word :
    req_addr == REG_MEAN_CUR ? I_MEAN_CURRENT : I_FAULT_CAUSE;

  // Parameter store, written only by an accepted write
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < PARAM_COUNT; i++) begin
        param_reg[i] <= PARAM_RESET;
      end
    end else if (I_CE && state_reg == ST_EXEC && good_wr && is_param) begin
      param_reg[pidx] <= req_val;
    end
  end

  // Command pulses and parameter notice last one cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_START_REQ <= 1'b0;
      O_STOP_REQ <= 1'b0;
      O_FAULT_RESET_REQ <= 1'b0;
      O_PARAM_WR <= 1'b0;
      O_PARAM_IDX <= 5'h00;
      O_PARAM_DATA <= 16'h0000;
    end else if (I_CE) begin
      O_START_REQ <= state_reg == ST_EXEC && good_wr && is_cmd && req_val[CMD_START_BIT];
      O_STOP_REQ <= state_reg == ST_EXEC && good_wr && is_cmd && req_val[CMD_STOP_BIT];
      O_FAULT_RESET_REQ <= state_reg == ST_EXEC && good_wr && is_cmd && req_val[CMD_RESET_BIT];
      O_PARAM_WR <= state_reg == ST_EXEC && good_wr && is_param;
      if (state_reg == ST_EXEC && good_wr && is_param) begin
        O_PARAM_IDX <= pidx;
        O_PARAM_DATA <= req_val;
      end
    end
  end

  // ==========================================================
  // Response assembly
  logic [7:0] resp_reg [0:5]; // Reply bytes before checksum
  logic [2:0] resp_len_reg; // Reply length before checksum
  logic [2:0] tx_idx_reg; // Next reply byte
  logic [15:0] tx_crc_reg; // Checksum of sent bytes
  wire logic push = to_fifo.valid && to_fifo.ready;
  wire logic last_byte = tx_idx_reg == resp_len_reg - 3'h1;

  // Reply built in one cycle from the decoded request
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      resp_len_reg <= 3'h0;
    end else if (I_CE && state_reg == ST_EXEC) begin
      resp_reg[0] <= rx_buf_reg[0];
      if (exc_code != EXC_NONE) begin
        resp_reg[1] <= req_fc | FC_EXC_BIT;
        resp_reg[2] <= exc_code;
        resp_len_reg <= 3'h3;
      end else if (is_rd) begin
        resp_reg[1] <= FC_READ;
        resp_reg[2] <= RD_BYTE_COUNT;
        resp_reg[3] <= rd_value[15:8];
        resp_reg[4] <= rd_value[7:0];
        resp_len_reg <= 3'h5;
      end else begin
        for (int i = 1; i < 6; i++) begin
          resp_reg[i] <= rx_buf_reg[i];
        end
        resp_len_reg <= 3'h6;
      end
    end
  end

  // Byte index and outgoing checksum
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      tx_idx_reg <= 3'h0;
      tx_crc_reg <= CRC_INIT;
    end else if (I_CE) begin
      if (state_reg == ST_EXEC) begin
        tx_idx_reg <= 3'h0;
        tx_crc_reg <= CRC_INIT;
      end else if (state_reg == ST_SEND && push) begin
        tx_idx_reg <= tx_idx_reg + 3'h1;
        tx_crc_reg <= crc16_byte(tx_crc_reg, to_fifo.data);
      end
    end
  end

  // Checksum goes out low byte first
  assign to_fifo.valid = state_reg == ST_SEND || state_reg == ST_CRCL || state_reg == ST_CRCH;
  assign to_fifo.data = state_reg == ST_CRCL ? tx_crc_reg[7:0] :
    state_reg == ST_CRCH ? tx_crc_reg[15:8] : resp_reg[tx_idx_reg];

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (frame_end && frame_good) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_SEND;
      end
      ST_SEND: begin
        if (push && last_byte) begin
          state_next = ST_CRCL;
        end
      end
      ST_CRCL: begin
        if (push) begin
          state_next = ST_CRCH;
        end
      end
      ST_CRCH: begin
        if (push) begin
          state_next = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // Driver stays on until the stop bit has left
        if (fifo_empty && !tx_busy) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State and line driver enable
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
      O_TX_EN <= 1'b0;
    end else if (I_CE) begin
      state_reg <= state_next;
      O_TX_EN <= state_next != ST_IDLE && state_next != ST_EXEC;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST || !I_CE);

  a_func_exception:
  assert property (state_reg == ST_EXEC && !(is_rd || is_wr) |=> state_reg == ST_SEND
    && resp_len_reg == 3'h3 && resp_reg[2] == EXC_FUNC)
    else $error("unsupported function not answered with code 01");

  a_exc_format:
  assert property (state_reg == ST_EXEC && exc_code != EXC_NONE |=> resp_reg[1] == ($past(req_fc) | FC_EXC_BIT))
    else $error("exception function byte lacks top bit");

  a_addr_exception:
  assert property (state_reg == ST_EXEC && is_wr && !wr_addr_ok |=> resp_reg[2] == EXC_ADDR && !O_PARAM_WR)
    else $error("bad write address not refused with code 02");

  a_value_exception:
  assert property (state_reg == ST_EXEC && is_wr && wr_addr_ok && val_bad
    |=> resp_reg[2] == EXC_VALUE && !O_PARAM_WR && !O_START_REQ)
    else $error("rejected value not refused with code 03");

  a_read_reply:
  assert property (state_reg == ST_EXEC && good_rd |=> resp_len_reg == 3'h5
    && resp_reg[2] == RD_BYTE_COUNT && {resp_reg[3], resp_reg[4]} == $past(rd_value))
    else $error("read reply malformed");

  a_write_echo:
  assert property (state_reg == ST_EXEC && good_wr |=> resp_len_reg == 3'h6
    && {resp_reg[2], resp_reg[3]} == $past(req_addr) && {resp_reg[4], resp_reg[5]} == $past(req_val))
    else $error("write echo differs from request");

  a_start_pulse:
  assert property (state_reg == ST_EXEC && good_wr && is_cmd && req_val[CMD_START_BIT]
    |=> O_START_REQ ##1 !O_START_REQ)
    else $error("start request not a single pulse");

  a_param_store:
  assert property (state_reg == ST_EXEC && good_wr && is_param |=> param_reg[$past(pidx)] == $past(req_val))
    else $error("parameter not stored");

  a_bad_frame_drop:
  assert property (frame_end && !frame_good |=> state_reg == ST_IDLE [*2])
    else $error("bad frame answered");

  a_gap_wait:
  assert property (rx_valid |=> !frame_end [*8])
    else $error("frame ended without idle gap");
endmodule : rtu_register_slave
`default_nettype wire

// ### bench/rtu_master_model.sv
// Behavioural serial master that sends requests and collects replies
`timescale 1ns/1ps
`default_nettype none
module rtu_master_model #(
  parameter int GAP = 72917, // Idle cycles before each request
  parameter int BIT = 2083 // Cycles per bit
) (
  input wire logic i_clk,
  input wire logic i_rxd,
  input wire logic i_tx_en,
  output logic o_txd
);
  typedef logic [7:0] byte_q_t[$];
  initial o_txd = 1'b1; // Line idles high
  // Reflected checksum, own copy
  function automatic logic [15:0] crc(input byte_q_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc
  // Checksum low byte first
  function automatic byte_q_t seal(input byte_q_t q);
    logic [15:0] c;
    c = crc(q);
    return {q, c[7:0], c[15:8]};
  endfunction : seal
  // Gap first, then 8N1 characters, bit 0 first
  task automatic send(input byte_q_t q);
    logic [9:0] f;
    repeat (GAP) @(posedge i_clk);
    foreach (q[j]) begin
      f = {1'b1, q[j], 1'b0};
      for (int i = 0; i < 10; i++) begin
        #1 o_txd = f[i];
        repeat (BIT) @(posedge i_clk);
      end
    end
  endtask : send
  // Mid-bit sampling on falling edges avoids races with the transmitter
  task automatic recv(output byte_q_t q);
    logic [7:0] b;
    q = {};
    wait (i_tx_en === 1'b1);
    while (i_tx_en === 1'b1) begin
      @(negedge i_clk);
      if (i_rxd === 1'b0) begin
        repeat (BIT / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(negedge i_clk);
          b = {i_rxd, b[7:1]};
        end
        repeat (BIT) @(negedge i_clk);
        q.push_back(b);
      end
    end
  endtask : recv
endmodule : rtu_master_model
`default_nettype wire

// ### bench/rtu_register_slave_tb_top.sv
// Self-checking bench for the serial register slave
`timescale 1ns/1ps
`default_nettype none
module rtu_register_slave_tb_top;
  localparam int BIT = 16; // Short bit keeps the run brief
  localparam int GAP = 560; // Three and a half characters of short bits
  typedef logic [7:0] bq_t[$];
  logic clk = 1'b0, rst = 1'b1, rxd, txd, tx_en, st, sp, fr, pwr;
  logic [3:0] stat = 4'h0;
  logic [18:0] pfix = 19'h00000, plock = 19'h00000;
  logic [15:0] cur = 16'h092E, fcause = 16'h0004, pdata;
  logic [4:0] idx;
  int err_count = 0, samples_checked = 0, cyc = 0, n_st = 0, n_sp = 0, n_fr = 0, n_wr = 0;
  always #25 clk = ~clk; // 20 MHz
  rtu_register_slave #(.GAP_CYCLES(GAP), .BIT_CYC(BIT)) dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1),
    .I_RXD(rxd), .I_STATION_ADDR(8'h02), .I_STARTING(stat[0]), .I_RUNNING(stat[1]),
    .I_SOFT_STOPPING(stat[2]), .I_FAULT(stat[3]), .I_MEAN_CURRENT(cur), .I_FAULT_CAUSE(fcause),
    .I_PARAM_FIXED(pfix), .I_PARAM_RUN_LOCKED(plock), .O_TXD(txd), .O_TX_EN(tx_en), .O_START_REQ(st),
    .O_STOP_REQ(sp), .O_FAULT_RESET_REQ(fr), .O_PARAM_WR(pwr), .O_PARAM_IDX(idx), .O_PARAM_DATA(pdata));
  rtu_master_model #(.GAP(GAP), .BIT(BIT)) m (.i_clk(clk), .i_rxd(txd), .i_tx_en(tx_en), .o_txd(rxd));
  // Pulse counters and hang guard
  always @(posedge clk) begin
    cyc++;
    if (st === 1'b1) n_st++;
    if (sp === 1'b1) n_sp++;
    if (fr === 1'b1) n_fr++;
    if (pwr === 1'b1) n_wr++;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // One request, expected reply compared byte by byte
  task automatic xact(input bq_t req, input bq_t exp);
    bq_t got;
    m.send(m.seal(req));
    m.recv(got);
    exp = m.seal(exp);
    chk(16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) chk(got[i], exp[i]);
  endtask : xact
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    xact({8'h02, 8'h06, 8'h00, 8'h01, 8'h00, 8'h07}, {8'h02, 8'h06, 8'h00, 8'h01, 8'h00, 8'h07});
    chk(16'(n_st), 16'h0001);
    chk(16'(n_sp), 16'h0001);
    chk(16'(n_fr), 16'h0001);
    @(posedge clk);
    #1 stat = 4'h9;
    xact({8'h02, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, {8'h02, 8'h03, 8'h02, 8'h00, 8'h09});
    xact({8'h02, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01}, {8'h02, 8'h03, 8'h02, 8'h09, 8'h2E});
    xact({8'h02, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01}, {8'h02, 8'h03, 8'h02, 8'h00, 8'h04});
    xact({8'h02, 8'h06, 8'h01, 8'h12, 8'h27, 8'h0F}, {8'h02, 8'h06, 8'h01, 8'h12, 8'h27, 8'h0F});
    chk(16'(n_wr), 16'h0001);
    chk({11'h000, idx}, 16'h0012);
    chk(pdata, 16'h270F);
    xact({8'h02, 8'h03, 8'h01, 8'h12, 8'h00, 8'h01}, {8'h02, 8'h03, 8'h02, 8'h27, 8'h0F});
    xact({8'h02, 8'h06, 8'h01, 8'h00, 8'h27, 8'h10}, {8'h02, 8'h86, 8'h03});
    xact({8'h02, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, {8'h02, 8'h83, 8'h02});
    xact({8'h02, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01}, {8'h02, 8'h84, 8'h01});
    chk(16'(n_wr), 16'h0001);
    xact({8'h02, 8'h03, 8'h00, 8'h02, 8'h00, 8'h02}, {8'h02, 8'h83, 8'h02});
    @(posedge clk);
    #1 pfix = 19'h00001;
    plock = 19'h00002;
    xact({8'h02, 8'h06, 8'h01, 8'h00, 8'h00, 8'h01}, {8'h02, 8'h86, 8'h03});
    xact({8'h02, 8'h06, 8'h01, 8'h01, 8'h00, 8'h01}, {8'h02, 8'h86, 8'h03});
    @(posedge clk);
    #1 stat = 4'h0;
    xact({8'h02, 8'h06, 8'h01, 8'h01, 8'h00, 8'h01}, {8'h02, 8'h06, 8'h01, 8'h01, 8'h00, 8'h01});
    chk(16'(n_wr), 16'h0002);
    m.send({8'h02, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00});
    repeat (GAP + 40) @(posedge clk);
    chk({15'h0000, tx_en}, 16'h0000);
    finish_test();
  end
endmodule : rtu_register_slave_tb_top
`default_nettype wire
